// file: rtl/ser_pkg.sv
package ser_pkg;
    // ********************************************************
    // sizes
    // ********************************************************
    localparam int RX_DEPTH = 3;
    localparam int TXS_W = 20;
    // ********************************************************
    // register indices behind the pointer
    // ********************************************************
    localparam logic [2:0] REG_CMD = 3'h0;
    localparam logic [2:0] REG_MODE = 3'h1;
    localparam logic [2:0] REG_VEC = 3'h2;
    localparam logic [2:0] REG_RXP = 3'h3;
    localparam logic [2:0] REG_MISC = 3'h4;
    localparam logic [2:0] REG_TXP = 3'h5;
    localparam logic [2:0] REG_SYNC_LO = 3'h6;
    localparam logic [2:0] REG_SYNC_HI = 3'h7;
    localparam logic [2:0] RD_MAIN = 3'h0;
    localparam logic [2:0] RD_SPECIAL = 3'h1;
    localparam logic [2:0] RD_VECTOR = 3'h2;
    localparam logic [7:0] REG_RST = 8'h00;
    // ********************************************************
    // fields
    // ********************************************************
    localparam int CMD_LSB = 3;
    localparam logic [2:0] CMD_NONE = 3'h0;
    localparam logic [2:0] CMD_RST_EXT = 3'h2;
    localparam logic [2:0] CMD_CH_RESET = 3'h3;
    localparam logic [2:0] CMD_ARM_RX = 3'h4;
    localparam logic [2:0] CMD_RST_TX = 3'h5;
    localparam logic [2:0] CMD_ERR_RST = 3'h6;
    localparam logic [2:0] CMD_RETI = 3'h7;
    localparam int M_EXT_EN = 0;
    localparam int M_TX_EN = 1;
    localparam int M_SAV = 2;
    localparam int M_RXM = 3;
    localparam int M_WR_RX = 5;
    localparam int M_WR_FN = 6;
    localparam int M_WR_EN = 7;
    localparam logic [1:0] RXM_OFF = 2'h0;
    localparam logic [1:0] RXM_FIRST = 2'h1;
    localparam logic [1:0] RXM_ALL_PAR = 2'h2;
    localparam int R_EN = 0;
    localparam int R_CRC = 3;
    localparam int R_LEN = 6;
    localparam int X_STOP = 2;
    localparam int X_SYNC = 4;
    localparam logic [1:0] STOP_SYNC = 2'h0;
    localparam logic [1:0] SYNC_BIT = 2'h2;
    localparam int T_EN = 3;
    localparam int S_RX_AVAIL = 0;
    localparam int S_INT_PEND = 1;
    localparam int S_TX_EMPTY = 2;
    localparam int S_DCD = 3;
    localparam int S_SYNC = 4;
    localparam int S_CTS = 5;
    localparam int S_CRC_SEND = 6;
    localparam int S_BRK = 7;
    localparam int P_ALL_SENT = 0;
    localparam int P_PARITY = 4;
    localparam int P_OVERRUN = 5;
    localparam int P_FRAME_CRC = 6;
    localparam int P_EOF = 7;
    localparam int VEC_LSB = 1;
    localparam logic [2:0] NO_INT_CODE = 3'h3;
    localparam logic [2:0] SLOT_RX = 3'h1;
    // ********************************************************
    // carriers
    // ********************************************************
    typedef struct packed {
        logic [7:0] data;
        logic parity_err;
        logic framing_err;
        logic crc_err;
        logic eof;
    } rx_char_s;
    typedef struct packed {
        logic cts;
        logic dcd;
        logic sync;
        logic brk;
        logic crc_send;
    } ext_pins_s;
    typedef struct packed {
        logic cs;
        logic rd;
        logic wr;
        logic chan_b;
        logic ctrl;
        logic [7:0] data;
    } bus_req_s;
    // lowest set index wins: slot 0 is the highest priority
    function automatic logic [3:0] first_set(input logic [7:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction : first_set
    function automatic logic [2:0] slot_code(input logic [2:0] s);
        logic [2:0] r;
        unique case (s)
            3'h0: r = 3'h7;
            3'h1: r = 3'h6;
            3'h2: r = 3'h4;
            3'h3: r = 3'h5;
            3'h4: r = 3'h3;
            3'h5: r = 3'h2;
            3'h6: r = 3'h0;
            3'h7: r = 3'h1;
        endcase
        return r;
    endfunction : slot_code
    function automatic logic [7:0] char_mask(input logic [1:0] len);
        logic [7:0] r;
        unique case (len)
            2'h0: r = 8'h1F;
            2'h1: r = 8'h7F;
            2'h2: r = 8'h3F;
            2'h3: r = 8'hFF;
        endcase
        return r;
    endfunction : char_mask
endpackage : ser_pkg

// file: rtl/dual_serial_host_irq_port.sv
`timescale 1ns/1ps
// ************************************************************
// Summary of operation
// RULE1 - main status per channel shows transfer needs
// RULE2 - crc error status valid only at frame end
// RULE3 - polling host keeps interrupts off, reads later
// RULE4 - vector bits three to one name source
// RULE5 - sources enabled singly; A before B; rx,tx,ext
// RULE6 - tx interrupt when written buffer goes empty
// RULE7 - receive interrupt on first or every character
// RULE8 - parity error may select the special vector
// RULE9 - special conditions interrupt only in receive modes
// RULE10 - after first char, specials except parity interrupt
// RULE11 - cts, dcd, sync transitions raise external status
// RULE12 - crc sending and break/abort raise external status
// RULE13 - break/abort interrupts at start and end
// RULE14 - acknowledge puts eight-bit vector on data
// RULE15 - three mode bits select wait or ready function
// RULE16 - ready when able; wait stalls the cpu access
// RULE17 - eight write, three read registers; vector on B
// RULE18 - reads give status, special status, modified vector
// RULE19 - write registers hold pointer, modes, sync chars
// RULE20 - three-deep receive fifo behind the shifter
// RULE21 - tx buffer feeds twenty-bit shifter or sync chars
// RULE22 - received chars steered to data or crc path
// RULE23 - pointer byte first, then data; reset clears pointer
// RULE24 - request while enabled source outranks any in service
// ************************************************************
module serial_rx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 3
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic clr,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;
    assign in_ready = (cnt_q != FULL);
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rp_q];
    assign push = in_valid & in_ready & ~clr;
    assign pop = out_valid & out_ready;
    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == LAST) ? '0 : p + 1'b1;
    endfunction : bump
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else if (clk_en && clr) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else if (clk_en) begin
            wp_q <= push ? bump(wp_q) : wp_q;
            rp_q <= pop ? bump(rp_q) : rp_q;
            cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
    always_ff @(posedge core_clk) begin
        if (clk_en && push) begin
            mem_q[wp_q] <= in_data;
        end
    end
endmodule : serial_rx_fifo

module dual_serial_host_irq_port (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire ser_pkg::bus_req_s bus,
    output logic bus_stall,
    output logic [7:0] rd_data,
    input wire logic intack,
    input wire logic reti,
    output logic int_req,
    output logic [1:0] wait_rdy_o,
    output logic [1:0] wait_rdy_oe_n,
    input wire ser_pkg::rx_char_s [1:0] rx_char,
    input wire logic [1:0] rx_valid,
    output logic [1:0] rx_ready,
    output logic [1:0] crc_valid,
    output logic [1:0][7:0] crc_data,
    output logic [1:0] tx_load_valid,
    output logic [1:0][ser_pkg::TXS_W-1:0] tx_load_word,
    input wire logic [1:0] tx_load_ready,
    input wire ser_pkg::ext_pins_s [1:0] ext
);
    // ********************************************************
    // state
    // ********************************************************
    logic [1:0][7:0][7:0] wreg_q;
    logic [1:0][2:0] ptr_q, ptr_d;
    logic [1:0] arm_q, arm_d, ovr_q, ovr_d, txfull_q, txfull_d;
    logic [1:0] tx_ip_q, tx_ip_d, ext_ip_q, ext_ip_d;
    logic [1:0][7:0] txbuf_q;
    logic [1:0][4:0] ext_prev_q;
    logic [1:0] crcv_q, txv_q;
    logic [1:0][7:0] crcd_q;
    logic [1:0][ser_pkg::TXS_W-1:0] txw_q, fill_w;
    logic [7:0] ius_q, ius_d, rd_data_q, rd_data_d;
    // ********************************************************
    // decode
    // ********************************************************
    logic take, pf, iuf, ack, reti_ev, sav;
    logic [3:0] p_hit, i_hit;
    logic [2:0] pidx, iidx;
    logic [7:0] pend, vec, vec_mod;
    logic [1:0] sel, ctl_wr, ctl_rd, dat_wr, dat_rd, cmd_wr, ch_rst;
    logic [1:0] fin_v, fout_v, ov_set, err_clr, ld_go, tx_empties;
    logic [1:0] fill, sync_md, rdy, acc_stall, sp_ev, ack_rx;
    logic [1:0][2:0] cmd;
    logic [1:0][1:0] rxm;
    logic [1:0][7:0] mode, rxp, misc, txp, main_st, spec_st;
    ser_pkg::rx_char_s [1:0] rx_in, head;

    assign bus_stall = |acc_stall;
    assign take = clk_en & bus.cs & (bus.rd | bus.wr) & ~bus_stall;
    assign rd_data = rd_data_q;
    assign crc_valid = crcv_q;
    assign crc_data = crcd_q;
    assign tx_load_valid = txv_q;
    assign tx_load_word = txw_q;

    for (genvar c = 0; c < 2; c++) begin : g_ch
        assign sel[c] = take & (bus.chan_b == 1'(c));
        assign ctl_wr[c] = sel[c] & bus.ctrl & bus.wr;
        assign ctl_rd[c] = sel[c] & bus.ctrl & ~bus.wr;
        assign dat_wr[c] = sel[c] & ~bus.ctrl & bus.wr;
        assign dat_rd[c] = sel[c] & ~bus.ctrl & ~bus.wr;
        assign cmd_wr[c] = ctl_wr[c] & (ptr_q[c] == ser_pkg::REG_CMD);
        assign cmd[c] = cmd_wr[c] ? bus.data[ser_pkg::CMD_LSB +: 3]
                                  : ser_pkg::CMD_NONE;
        assign ch_rst[c] = (cmd[c] == ser_pkg::CMD_CH_RESET);
        assign mode[c] = wreg_q[c][ser_pkg::REG_MODE];
        assign rxp[c] = wreg_q[c][ser_pkg::REG_RXP];
        assign misc[c] = wreg_q[c][ser_pkg::REG_MISC];
        assign txp[c] = wreg_q[c][ser_pkg::REG_TXP];
        assign rxm[c] = mode[c][ser_pkg::M_RXM +: 2];
        assign sync_md[c] = misc[c][ser_pkg::X_STOP +: 2]
                            == ser_pkg::STOP_SYNC;
        // RULE23 pointer then data
        assign ptr_d[c] = (ch_rst[c] | (ctl_wr[c] & ~cmd_wr[c])
                           | ctl_rd[c]) ? ser_pkg::REG_CMD
                        : cmd_wr[c] ? bus.data[2:0] : ptr_q[c];
        // RULE22 length mask only when async
        assign rx_in[c] = {rx_char[c].data & (sync_md[c] ? 8'hFF
                           : ser_pkg::char_mask(rxp[c][ser_pkg::R_LEN +: 2])),
                           rx_char[c][3:0]};
        assign fin_v[c] = rx_valid[c] & rxp[c][ser_pkg::R_EN];
        // RULE20 three buffers behind shifter
        serial_rx_fifo #(
            .WIDTH($bits(ser_pkg::rx_char_s)),
            .DEPTH(ser_pkg::RX_DEPTH)
        ) u_rx_fifo (
            .core_clk(core_clk),
            .rst(rst),
            .clk_en(clk_en),
            .clr(ch_rst[c]),
            .in_valid(fin_v[c]),
            .in_ready(rx_ready[c]),
            .in_data(rx_in[c]),
            .out_valid(fout_v[c]),
            .out_ready(dat_rd[c]),
            .out_data(head[c])
        );
        // overrun: set beats error reset
        assign ov_set[c] = fin_v[c] & ~rx_ready[c];
        assign err_clr[c] = ch_rst[c] | (cmd[c] == ser_pkg::CMD_ERR_RST);
        assign ovr_d[c] = ov_set[c] | (ovr_q[c] & ~err_clr[c]);
        // RULE10 parity counts only in all-chars-with-parity option
        assign sp_ev[c] = ovr_q[c] | (fout_v[c] & (head[c].framing_err
                          | head[c].eof | (head[c].parity_err
                          & (rxm[c] == ser_pkg::RXM_ALL_PAR))));
        assign ack_rx[c] = ack & (pidx == {1'(c), 2'(ser_pkg::SLOT_RX)});
        // RULE7 first char arms once
        assign arm_d[c] = ch_rst[c] | (cmd[c] == ser_pkg::CMD_ARM_RX)
                          | (arm_q[c] & ~ack_rx[c]);
        // RULE5 RULE9 each source gated by its enable
        assign pend[4*c +: 4] = {
            ext_ip_q[c] & mode[c][ser_pkg::M_EXT_EN],
            tx_ip_q[c] & mode[c][ser_pkg::M_TX_EN],
            fout_v[c] & (rxm[c][1] | ((rxm[c] == ser_pkg::RXM_FIRST)
                                      & arm_q[c])),
            sp_ev[c] & (rxm[c] != ser_pkg::RXM_OFF)};
        // RULE21 buffer or sync chars into shifter
        assign ld_go[c] = txp[c][ser_pkg::T_EN]
                          & (~txv_q[c] | tx_load_ready[c]);
        assign tx_empties[c] = ld_go[c] & txfull_q[c];
        assign fill[c] = ld_go[c] & ~txfull_q[c] & sync_md[c];
        assign fill_w[c] = (misc[c][ser_pkg::X_SYNC +: 2]
                            == ser_pkg::SYNC_BIT)
            ? {12'h000, wreg_q[c][ser_pkg::REG_SYNC_HI]}
            : {4'h0, wreg_q[c][ser_pkg::REG_SYNC_HI],
               wreg_q[c][ser_pkg::REG_SYNC_LO]};
        assign txfull_d[c] = dat_wr[c]
                             | (txfull_q[c] & ~tx_empties[c] & ~ch_rst[c]);
        // RULE6 empty after a written char
        assign tx_ip_d[c] = tx_empties[c] | (tx_ip_q[c] & ~ch_rst[c]
                            & ~dat_wr[c] & (cmd[c] != ser_pkg::CMD_RST_TX));
        // RULE11 RULE12 RULE13 any edge of pins
        assign ext_ip_d[c] = (ext[c] != ext_prev_q[c])
                             | (ext_ip_q[c] & ~ch_rst[c]
                                & (cmd[c] != ser_pkg::CMD_RST_EXT));
        // RULE15 RULE16 wait stalls, ready drives
        assign rdy[c] = mode[c][ser_pkg::M_WR_RX] ? fout_v[c] : ~txfull_q[c];
        assign acc_stall[c] = mode[c][ser_pkg::M_WR_EN]
            & ~mode[c][ser_pkg::M_WR_FN] & ~rdy[c] & bus.cs & ~bus.ctrl
            & (bus.chan_b == 1'(c))
            & (mode[c][ser_pkg::M_WR_RX] ? bus.rd & ~bus.wr : bus.wr);
        assign wait_rdy_oe_n[c] = ~(mode[c][ser_pkg::M_WR_EN]
            & (mode[c][ser_pkg::M_WR_FN] | acc_stall[c]));
        assign wait_rdy_o[c] = mode[c][ser_pkg::M_WR_FN] & ~rdy[c];
        // RULE1 RULE18 status images
        always_comb begin
            main_st[c] = 8'h00;
            main_st[c][ser_pkg::S_RX_AVAIL] = fout_v[c];
            main_st[c][ser_pkg::S_INT_PEND] = (c == 0) & pf;
            main_st[c][ser_pkg::S_TX_EMPTY] = ~txfull_q[c];
            main_st[c][ser_pkg::S_DCD] = ext[c].dcd;
            main_st[c][ser_pkg::S_SYNC] = ext[c].sync;
            main_st[c][ser_pkg::S_CTS] = ext[c].cts;
            main_st[c][ser_pkg::S_CRC_SEND] = ext[c].crc_send;
            main_st[c][ser_pkg::S_BRK] = ext[c].brk;
            spec_st[c] = 8'h00;
            spec_st[c][ser_pkg::P_ALL_SENT] = ~txfull_q[c] & ~txv_q[c];
            spec_st[c][ser_pkg::P_PARITY] = fout_v[c] & head[c].parity_err;
            spec_st[c][ser_pkg::P_OVERRUN] = ovr_q[c];
            // RULE2 crc error only with end of frame
            spec_st[c][ser_pkg::P_FRAME_CRC] = fout_v[c]
                & (head[c].framing_err | (head[c].eof & head[c].crc_err));
            spec_st[c][ser_pkg::P_EOF] = fout_v[c] & head[c].eof;
        end
        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                wreg_q[c] <= '0;
                ptr_q[c] <= ser_pkg::REG_CMD;
                {arm_q[c], ovr_q[c], txfull_q[c]} <= 3'h4;
                {tx_ip_q[c], ext_ip_q[c], crcv_q[c], txv_q[c]} <= 4'h0;
                ext_prev_q[c] <= 5'h00;
                txbuf_q[c] <= 8'h00;
                crcd_q[c] <= 8'h00;
                txw_q[c] <= '0;
            end else if (clk_en) begin
                ptr_q[c] <= ptr_d[c];
                {arm_q[c], ovr_q[c], txfull_q[c]} <=
                    {arm_d[c], ovr_d[c], txfull_d[c]};
                {tx_ip_q[c], ext_ip_q[c]} <= {tx_ip_d[c], ext_ip_d[c]};
                ext_prev_q[c] <= ext[c];
                // RULE17 RULE19 vector index exists on B only
                if (ch_rst[c]) begin
                    wreg_q[c] <= '0;
                end else if (ctl_wr[c] & ~cmd_wr[c]
                             & ~(c == 0 && ptr_q[c] == ser_pkg::REG_VEC)) begin
                    wreg_q[c][ptr_q[c]] <= bus.data;
                end
                txbuf_q[c] <= dat_wr[c] ? bus.data : txbuf_q[c];
                // RULE22 crc path in sync modes
                crcv_q[c] <= fin_v[c] & rx_ready[c] & sync_md[c]
                             & rxp[c][ser_pkg::R_CRC];
                crcd_q[c] <= rx_in[c].data;
                if (ld_go[c]) begin
                    txv_q[c] <= txfull_q[c] | fill[c];
                    txw_q[c] <= txfull_q[c] ? {12'h000, txbuf_q[c]}
                                            : fill_w[c];
                end
            end
        end
    end

    // ********************************************************
    // interrupt priority and vector
    // ********************************************************
    assign vec = wreg_q[1][ser_pkg::REG_VEC];
    assign sav = mode[1][ser_pkg::M_SAV];
    assign p_hit = ser_pkg::first_set(pend);
    assign i_hit = ser_pkg::first_set(ius_q);
    assign {pf, pidx} = p_hit;
    assign {iuf, iidx} = i_hit;
    // RULE24 masked by the same or a higher one in service
    assign int_req = pf & (~iuf | (pidx < iidx));
    assign ack = clk_en & intack & int_req;
    // RULE4 RULE8 three code bits replaced
    assign vec_mod = sav ? {vec[7:4], pf ? ser_pkg::slot_code(pidx)
                            : ser_pkg::NO_INT_CODE, vec[0]} : vec;
    assign reti_ev = iuf & ((clk_en & reti)
                     | (cmd[0] == ser_pkg::CMD_RETI));
    assign ius_d = (ius_q | (ack ? 8'h01 << pidx : 8'h00))
                   & ~(reti_ev ? 8'h01 << iidx : 8'h00);
    // RULE14 RULE18 acknowledge outranks a bus read
    always_comb begin
        rd_data_d = rd_data_q;
        if (ack) begin
            rd_data_d = vec_mod;
        end else if (dat_rd[bus.chan_b]) begin
            rd_data_d = head[bus.chan_b].data;
        end else if (ctl_rd[bus.chan_b]) begin
            case (ptr_q[bus.chan_b])
                ser_pkg::RD_MAIN: rd_data_d = main_st[bus.chan_b];
                ser_pkg::RD_SPECIAL: rd_data_d = spec_st[bus.chan_b];
                ser_pkg::RD_VECTOR: rd_data_d = bus.chan_b ? vec_mod : 8'h00;
                default: rd_data_d = 8'h00;
            endcase
        end
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ius_q <= 8'h00;
            rd_data_q <= 8'h00;
        end else if (clk_en) begin
            ius_q <= ius_d;
            rd_data_q <= rd_data_d;
        end
    end

    // ********************************************************
    // checks
    // ********************************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    sequence s_point_mode;
        cmd_wr[1] && !ch_rst[1] && bus.data[2:0] == ser_pkg::REG_MODE;
    endsequence
    sequence s_ack_first_b;
        ack && pidx == {1'b1, ser_pkg::SLOT_RX[1:0]}
        && rxm[1] == ser_pkg::RXM_FIRST;
    endsequence
    sequence s_brk_edge_b;
        clk_en && ext[1].brk != ext_prev_q[1][1];
    endsequence
    AST_PTR_SET: assert property ( // RULE23
        s_point_mode |=> ptr_q[1] == ser_pkg::REG_MODE ##0 !ch_rst[1])
        else $error("pointer not loaded");
    AST_PTR_BACK: assert property ( // RULE23
        ctl_wr[1] && ptr_q[1] != ser_pkg::REG_CMD |=> ptr_q[1] == 3'h0)
        else $error("pointer did not return");
    AST_FIRST_ONCE: assert property ( // RULE7
        s_ack_first_b |=> !arm_q[1] && !pend[5])
        else $error("first char still armed");
    AST_VEC_MOD: assert property ( // RULE4
        ack && sav |=> rd_data_q[3:1] == ser_pkg::slot_code($past(pidx))
                   && ius_q[$past(pidx)])
        else $error("vector code wrong");
    AST_PRIO_AB: assert property ( // RULE5
        (|pend[3:0]) |-> !pidx[2])
        else $error("channel B beat channel A");
    AST_SPECIAL_OFF: assert property ( // RULE9
        rxm[0] == ser_pkg::RXM_OFF |-> !pend[0] && !pend[1])
        else $error("receive source while off");
    AST_BRK_BOTH: assert property ( // RULE13
        s_brk_edge_b |=> ext_ip_q[1])
        else $error("break edge lost");
    AST_TX_EMPTY: assert property ( // RULE6
        clk_en && tx_empties[1] && !dat_wr[1] |=> tx_ip_q[1] && !txfull_q[1])
        else $error("tx empty not flagged");
    AST_WAIT_HOLD: assert property ( // RULE16
        acc_stall[0] |-> !take && !wait_rdy_oe_n[0] && !wait_rdy_o[0])
        else $error("wait not asserted");
    AST_REQ_MASK: assert property ( // RULE24
        iuf && pf && pidx >= iidx |-> !int_req)
        else $error("request through service mask");
endmodule : dual_serial_host_irq_port

// file: verif/serial_side_model.sv
`timescale 1ns/1ps
// ********************************************************
// serial channel side: receive source, slow transmit shifter
// ********************************************************
module serial_side_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [1:0] send,
    input wire logic [7:0] send_data,
    output ser_pkg::rx_char_s [1:0] rx_char,
    output logic [1:0] rx_valid,
    input wire logic [1:0] rx_ready,
    input wire logic [1:0] tx_load_valid,
    input wire logic [1:0][ser_pkg::TXS_W-1:0] tx_load_word,
    output logic [1:0] tx_load_ready,
    output logic [ser_pkg::TXS_W-1:0] last_word
);
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_valid <= '0;
            rx_char <= '0;
            tx_load_ready <= '0;
            last_word <= '0;
        end else begin
            // shifter takes a word every other cycle, a real stall
            tx_load_ready <= ~tx_load_ready;
            for (int i = 0; i < 2; i++) begin
                if (send[i]) begin
                    rx_valid[i] <= 1'b1;
                    rx_char[i] <= '{data: send_data, default: 1'b0};
                end else if (rx_valid[i] && rx_ready[i]) begin
                    rx_valid[i] <= 1'b0;
                    // taken data no longer shows its old value
                    rx_char[i].data <= ~rx_char[i].data;
                end
                if (tx_load_valid[i] && tx_load_ready[i]) begin
                    last_word <= tx_load_word[i];
                end
            end
        end
    end
endmodule : serial_side_model

// file: verif/dual_serial_host_irq_port_tb.sv
`timescale 1ns/1ps
module dual_serial_host_irq_port_tb;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic intack = 1'b0;
    logic reti = 1'b0;
    logic [1:0] send = '0;
    logic [7:0] rdv;
    ser_pkg::bus_req_s bus = '0;
    ser_pkg::ext_pins_s [1:0] ext = '0;
    ser_pkg::rx_char_s [1:0] rx_char;
    logic [1:0] rx_valid, rx_ready, tx_load_valid, tx_load_ready;
    logic [1:0][ser_pkg::TXS_W-1:0] tx_load_word;
    logic [ser_pkg::TXS_W-1:0] last_word;
    logic int_req, bus_stall;
    logic [7:0] rd_data;
    int n_mismatch = 0;
    int n_compared = 0;
    always #5 core_clk = ~core_clk;
    dual_serial_host_irq_port i_dut (.core_clk(core_clk), .rst(rst),
        .clk_en(1'b1), .bus(bus), .bus_stall(bus_stall), .rd_data(rd_data),
        .intack(intack), .reti(reti), .int_req(int_req), .wait_rdy_o(),
        .wait_rdy_oe_n(), .rx_char(rx_char), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .crc_valid(), .crc_data(),
        .tx_load_valid(tx_load_valid), .tx_load_word(tx_load_word),
        .tx_load_ready(tx_load_ready), .ext(ext));
    serial_side_model i_side (.core_clk(core_clk), .rst(rst), .send(send),
        .send_data(8'h5A), .rx_char(rx_char), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .tx_load_valid(tx_load_valid),
        .tx_load_word(tx_load_word), .tx_load_ready(tx_load_ready),
        .last_word(last_word));
    // ********************************************************
    // shared tasks
    // ********************************************************
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: byte %h want %h", $time, g, e);
        end
    endtask : chk8
    task automatic chk1(input logic g, input logic e);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: flag %b want %b", $time, g, e);
        end
    endtask : chk1
    // wait mode stays off, so one edge takes the access
    task automatic cyc(input logic b, input logic c, input logic w,
                       input logic [7:0] d);
        @(posedge core_clk);
        bus <= '{cs: 1'b1, rd: ~w, wr: w, chan_b: b, ctrl: c, data: d};
        @(posedge core_clk);
        bus <= '0;
        #1 rdv = rd_data;
    endtask : cyc
    task automatic wreg(input logic [2:0] r, input logic [7:0] v);
        cyc(1'b1, 1'b1, 1'b1, {5'h00, r});
        cyc(1'b1, 1'b1, 1'b1, v);
    endtask : wreg
    task automatic ack(input logic [7:0] e);
        for (int i = 0; i < 20 && int_req !== 1'b1; i++) @(posedge core_clk);
        #1 chk1(int_req, 1'b1);
        @(posedge core_clk);
        intack <= 1'b1;
        @(posedge core_clk);
        intack <= 1'b0;
        #1 chk8(rd_data, e);
    endtask : ack
    task automatic ret;
        @(posedge core_clk);
        reti <= 1'b1;
        @(posedge core_clk);
        reti <= 1'b0;
        #1;
    endtask : ret
    // ********************************************************
    // scenarios
    // ********************************************************
    task automatic test_rx;
        cyc(1'b1, 1'b1, 1'b0, 8'h00);
        chk8(rdv, 8'h04);
        wreg(ser_pkg::REG_VEC, 8'hF0);
        wreg(ser_pkg::REG_RXP, 8'hC1);
        // first pass first-char mode, second pass every char
        for (int m = 0; m < 2; m++) begin
            wreg(ser_pkg::REG_MODE, m ? 8'h1C : 8'h0C);
            @(posedge core_clk);
            send <= 2'b10;
            @(posedge core_clk);
            send <= 2'b00;
            ack(8'hF4);
            cyc(1'b1, 1'b1, 1'b0, 8'h00);
            chk8(rdv & 8'h01, 8'h01);
            cyc(1'b1, 1'b0, 1'b0, 8'h00);
            chk8(rdv, 8'h5A);
            ret();
        end
        $display("test_rx done");
    endtask : test_rx
    task automatic test_tx;
        wreg(ser_pkg::REG_MODE, 8'h06);
        // async stop bits, so no sync fill follows the byte
        wreg(ser_pkg::REG_MISC, 8'h04);
        wreg(ser_pkg::REG_TXP, 8'h08);
        chk1(int_req, 1'b0);
        cyc(1'b1, 1'b0, 1'b1, 8'hA5);
        ack(8'hF0);
        chk8(last_word[7:0], 8'hA5);
        cyc(1'b1, 1'b1, 1'b1, 8'h28);
        ret();
        chk1(int_req, 1'b0);
        $display("test_tx done");
    endtask : test_tx
    task automatic test_ext;
        wreg(ser_pkg::REG_MODE, 8'h05);
        for (int i = 0; i < 3; i++) begin
            @(posedge core_clk);
            ext[1] <= '{cts: (i == 2), brk: (i == 0), default: 1'b0};
            ack(8'hF2);
            cyc(1'b1, 1'b1, 1'b1, 8'h10);
            ret();
        end
        cyc(1'b0, 1'b1, 1'b1, 8'h01);
        cyc(1'b0, 1'b1, 1'b1, 8'h01);
        @(posedge core_clk);
        ext <= '1;
        ack(8'hFA);
        chk1(int_req, 1'b0);
        cyc(1'b0, 1'b1, 1'b1, 8'h10);
        ret();
        ack(8'hF2);
        $display("test_ext done");
    endtask : test_ext
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        test_rx();
        test_tx();
        test_ext();
        test_done();
    end
    // whole run needs well under a thousand cycles
    initial begin
        #100000;
        n_mismatch++;
        $display("unexpected at %0t: run hung", $time);
        test_done();
    end
endmodule : dual_serial_host_irq_port_tb
